// ==== hdl/pir_pkg.sv ====
/*
 * Package for the shared interrupt request router: register map, field
 * layouts, reset values, mode encoding and the carrier structs.
 * Assumes a 32-bit classic Wishbone slave port and one 100 MHz clock.
 */
package pir_pkg;

    // geometry
    localparam int PIR_LINES = 8;
    localparam int PIR_IRQS = 24;
    localparam int PIR_LEGACY_IRQS = 16;
    localparam int PIR_ADV_BASE = 16;
    localparam int PIR_SEL_W = 4;
    localparam int PIR_SLOTS = 2;
    localparam int PIR_ONBOARD = 2;

    // register byte offsets
    localparam logic [7:0] PIR_OFF_CTRL = 8'h00;
    localparam logic [7:0] PIR_OFF_STEER = 8'h04;
    localparam logic [7:0] PIR_OFF_LINES = 8'h08;
    localparam logic [7:0] PIR_OFF_IRQS = 8'h0C;

    // control register fields
    localparam int PIR_CTRL_MODE_BIT = 0;

    // reset values
    localparam logic [31:0] PIR_STEER_RST = 32'h0000_0000;

    // steering value zero means the line is not routed in legacy mode
    localparam logic [PIR_SEL_W-1:0] PIR_SEL_NONE = 4'h0;

    // legacy irq numbers that a shared line may select
    localparam logic [15:0] PIR_LEGACY_ALLOWED = 16'hDEF8;

    // irq numbers held by fixed system resources
    localparam int PIR_IRQ_TIMER = 0;
    localparam int PIR_IRQ_KEYBOARD = 1;
    localparam int PIR_IRQ_CASCADE = 2;
    localparam int PIR_IRQ_RTC = 8;

    // shared line indices
    localparam int PIR_LINE_A = 0;
    localparam int PIR_LINE_B = 1;
    localparam int PIR_LINE_C = 2;
    localparam int PIR_LINE_D = 3;
    localparam int PIR_LINE_E = 4;
    localparam int PIR_LINE_F = 5;
    localparam int PIR_LINE_G = 6;
    localparam int PIR_LINE_H = 7;

    // interrupt controller modes
    typedef enum logic {
        PIR_LEGACY_CONTROLLER_MODE = 1'b0,
        PIR_ADVANCED_CONTROLLER_MODE = 1'b1
    } pir_mode_t;

    // four active-low pins of one pci agent
    typedef struct packed {
        logic int_d_n;
        logic int_c_n;
        logic int_b_n;
        logic int_a_n;
    } pir_pins_t;

    // wishbone request from the master
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [7:0] adr;
        logic [31:0] dat;
    } pir_wb_req_t;

endpackage

// ==== hdl/pir_router.sv ====
/*
 * Shared interrupt request router: gathers slot and onboard pci interrupt
 * pins onto eight shared request lines and steers them to system irqs.
 * Also holds the helper modules it uses: a two-stage synchroniser, the
 * per-line legacy steering decoder and the outward level register.
 * Assumes pins come from outside the clock domain, a classic Wishbone
 * master on the register port and a downstream controller taking levels.
 * clk_en low freezes every flop, synchroniser stages included, so a pin
 * that changes while frozen is seen only after the enable returns.
 * Lines A to C have no source on this board; they stay low but keep their
 * places so the advanced map of lines onto irqs stays one-to-one.
 */
// Implementation choices: the address map and the Wishbone interface to the registers.
// Overview of operation
// - There are exactly eight shared request lines, A to H, that carry every pci source.
// - Legacy controller mode offers only irq numbers 0 to 15.
// - Advanced controller mode offers twenty-four irq inputs, 0 to 23.
// - Irqs 16 to 23 are driven only in advanced mode and stay quiet in legacy mode.
// - In advanced mode lines A to H drive irqs 16 to 23 in order.
// - In legacy mode each line is steered to one of irqs 3-7, 9-12, 14 or 15.
// - In legacy mode several lines may select one irq and are then merged.
// - Sources wired onto one line form one request; any asserting source raises it.
// - Slot 1 pins A-D go to lines F,G,H,E and slot 2 pins A-D to lines G,F,E,H.
// - Onboard ethernet drives line E and onboard 1394 controller drives line D.
// - Irqs 0, 1, 2 and 8 are reserved and never driven by the router.
module pir_router
    import pir_pkg::*;
(
    // clock, reset, enable
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic clk_en,
    // pci interrupt pins, active low
    input wire pir_pins_t slot_pins [PIR_SLOTS],
    input wire logic enet_int_a_n,
    input wire logic fw_int_a_n,
    // classic wishbone slave
    input wire pir_wb_req_t wb_req,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // to the interrupt controller, active high levels
    output logic [PIR_IRQS-1:0] irq_out,
    output logic [PIR_LINES-1:0] shared_req_lines
);

    // synchroniser stages for all raw pins
    localparam int RAW_W = 4 * PIR_SLOTS + PIR_ONBOARD;

    // bit positions of each pin in the raw vector: slot 1, slot 2, onboard
    localparam int RAW_S1_A = 0;
    localparam int RAW_S1_B = 1;
    localparam int RAW_S1_C = 2;
    localparam int RAW_S1_D = 3;
    localparam int RAW_S2_A = 4;
    localparam int RAW_S2_B = 5;
    localparam int RAW_S2_C = 6;
    localparam int RAW_S2_D = 7;
    localparam int RAW_ENET = 8;
    localparam int RAW_FW = 9;

    logic [RAW_W-1:0] raw_n;
    logic [RAW_W-1:0] sync2_n;
    logic [PIR_LINES-1:0] next_lines;
    logic [PIR_IRQS-1:0] next_adv_irq;
    logic [PIR_IRQS-1:0] next_leg_irq;
    logic [PIR_LEGACY_IRQS-1:0] leg_or;
    logic [PIR_LEGACY_IRQS-1:0] leg_mask [PIR_LINES];
    logic [PIR_IRQS-1:0] next_irq;
    pir_mode_t ctrl_mode;
    logic [PIR_SEL_W-1:0] steer [PIR_LINES];
    logic [31:0] next_rdata;
    logic wb_hit;
    // helper strobes of the register port
    logic ctrl_wr;
    logic steer_wr;
    logic rd_take;

    // the raw vector keeps the order of the positions above
    assign raw_n = {fw_int_a_n, enet_int_a_n, slot_pins[1], slot_pins[0]};

    // asynchronous level pins pass two flops, reset to the idle high level
    pir_sync2 #(
        .W(RAW_W),
        .IDLE({RAW_W{1'b1}})
    ) pin_sync (
        .core_clk(core_clk),
        .nrst(nrst),
        .clk_en(clk_en),
        .d(raw_n),
        .q(sync2_n)
    );

    // wired sharing of the synchronised pins
    always_comb begin
        // active high levels from the active low pins
        // lines A to C have no source and stay low
        next_lines = '0;
        next_lines[PIR_LINE_F] = ~sync2_n[RAW_S1_A] | ~sync2_n[RAW_S2_B];
        next_lines[PIR_LINE_G] = ~sync2_n[RAW_S1_B] | ~sync2_n[RAW_S2_A];
        next_lines[PIR_LINE_H] = ~sync2_n[RAW_S1_C] | ~sync2_n[RAW_S2_D];
        next_lines[PIR_LINE_E] = ~sync2_n[RAW_S1_D] | ~sync2_n[RAW_S2_C] | ~sync2_n[RAW_ENET];
        next_lines[PIR_LINE_D] = ~sync2_n[RAW_FW];
    end

    // steerable legacy irq
    // one decoder per line; lines that pick the same code just share a bit
    for (genvar g = 0; g < PIR_LINES; g++) begin : g_steer
        pir_steer_dec #(
            .SEL_W(PIR_SEL_W),
            .N_IRQ(PIR_LEGACY_IRQS),
            .ALLOWED(PIR_LEGACY_ALLOWED)
        ) dec (
            .sel(steer[g]),
            .mask(leg_mask[g])
        );
    end

    // advanced mode: fixed map of the lines onto the upper eight irqs
    always_comb begin
        next_adv_irq = '0;
        for (int i = 0; i < PIR_LINES; i++) begin
            next_adv_irq[PIR_ADV_BASE + i] = shared_req_lines[i];
        end
    end

    // legacy mode: or of every asserted line that steers onto an irq
    always_comb begin
        leg_or = '0;
        for (int i = 0; i < PIR_LINES; i++) begin
            if (shared_req_lines[i]) begin
                leg_or = leg_or | leg_mask[i];
            end
        end
    end

    assign next_leg_irq = {{(PIR_IRQS - PIR_LEGACY_IRQS){1'b0}}, leg_or};

    // mode select; reserved numbers are forced quiet whichever mode runs
    always_comb begin
        if (ctrl_mode == PIR_ADVANCED_CONTROLLER_MODE) begin
            next_irq = next_adv_irq;
        end else begin
            next_irq = next_leg_irq;
        end
        next_irq[PIR_IRQ_TIMER] = 1'b0;
        next_irq[PIR_IRQ_KEYBOARD] = 1'b0;
        next_irq[PIR_IRQ_CASCADE] = 1'b0;
        next_irq[PIR_IRQ_RTC] = 1'b0;
    end

    pir_level_reg #(
        .W(PIR_LINES)
    ) line_reg (
        .core_clk(core_clk),
        .nrst(nrst),
        .clk_en(clk_en),
        .d(next_lines),
        .q(shared_req_lines)
    );

    // registered irq outputs lag the lines by one cycle
    // high irqs advanced only
    pir_level_reg #(
        .W(PIR_IRQS)
    ) irq_reg (
        .core_clk(core_clk),
        .nrst(nrst),
        .clk_en(clk_en),
        .d(next_irq),
        .q(irq_out)
    );

    // a request is taken in the cycle ack is low, so ack is one cycle wide;
    // a master that keeps stb up after ack is simply served a second time
    assign wb_hit = clk_en && wb_req.cyc && wb_req.stb && !wb_ack_o;

    // byte lane 0 carries the mode bit; other lanes of the control word are ignored
    assign ctrl_wr = wb_hit && wb_req.we && wb_req.sel[0] && wb_req.adr == PIR_OFF_CTRL;
    // steering writes are gated per nibble by the lanes further down
    assign steer_wr = wb_hit && wb_req.we && wb_req.adr == PIR_OFF_STEER;
    // read data is captured only when a read is taken, so it holds until the next
    assign rd_take = wb_hit && !wb_req.we;

    // ack follows a taken request by one edge
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            wb_ack_o <= 1'b0;
        end else if (clk_en) begin
            wb_ack_o <= wb_hit;
        end
    end

    // control register: mode bit in byte lane 0
    // a write with lane 0 off leaves the mode alone
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            ctrl_mode <= PIR_LEGACY_CONTROLLER_MODE;
        end else if (ctrl_wr) begin
            ctrl_mode <= pir_mode_t'(wb_req.dat[PIR_CTRL_MODE_BIT]);
        end
    end

    // steering register: one nibble per line, a nibble outside the allowed
    // set is stored as written but routes nowhere, which keeps reads honest
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            for (int i = 0; i < PIR_LINES; i++) begin
                steer[i] <= PIR_STEER_RST[i*PIR_SEL_W +: PIR_SEL_W];
            end
        end else if (steer_wr) begin
            for (int i = 0; i < PIR_LINES; i++) begin
                if (wb_req.sel[i/2]) begin
                    steer[i] <= wb_req.dat[i*PIR_SEL_W +: PIR_SEL_W];
                end
            end
        end
    end

    // read mux; unmapped offsets read zero and still acknowledge
    // reads have no side effect, so a repeated read is harmless
    always_comb begin
        next_rdata = '0;
        unique case (wb_req.adr)
            PIR_OFF_CTRL: next_rdata[PIR_CTRL_MODE_BIT] = ctrl_mode;
            PIR_OFF_STEER: begin
                for (int i = 0; i < PIR_LINES; i++) begin
                    next_rdata[i*PIR_SEL_W +: PIR_SEL_W] = steer[i];
                end
            end
            PIR_OFF_LINES: next_rdata[PIR_LINES-1:0] = shared_req_lines;
            PIR_OFF_IRQS: next_rdata[PIR_IRQS-1:0] = irq_out;
            default: next_rdata = '0;
        endcase
    end

    // read data register, held between reads
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            wb_dat_o <= '0;
        end else if (rd_take) begin
            wb_dat_o <= next_rdata;
        end
    end

endmodule

// two-stage level synchroniser; the first stage is read by the second alone,
// so a metastable sample never reaches the sharing logic
module pir_sync2 #(
    parameter int W = 1,
    parameter logic [W-1:0] IDLE = '0
) (
    // clock, reset, enable
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic clk_en,
    // raw levels in, settled levels out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta;

    // first stage; reset to idle so no false request shows after reset
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            meta <= IDLE;
        end else if (clk_en) begin
            meta <= d;
        end
    end

    // second stage, the only reader of the first
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            q <= IDLE;
        end else if (clk_en) begin
            q <= meta;
        end
    end

endmodule

// decodes one steering code into a one-hot mask of legacy irqs; the unrouted
// code zero and every code outside the allowed set give an empty mask, so a
// stray write can never reach a reserved number
module pir_steer_dec
    import pir_pkg::*;
#(
    parameter int SEL_W = PIR_SEL_W,
    parameter int N_IRQ = PIR_LEGACY_IRQS,
    parameter logic [N_IRQ-1:0] ALLOWED = PIR_LEGACY_ALLOWED
) (
    // steering code of one shared line
    input wire logic [SEL_W-1:0] sel,
    // one-hot legacy irq mask, empty when unrouted
    output logic [N_IRQ-1:0] mask
);

    always_comb begin
        mask = '0;
        for (int q = 0; q < N_IRQ; q++) begin
            if (sel == SEL_W'(q)) begin
                mask[q] = ALLOWED[q];
            end
        end
    end

endmodule

// plain register with synchronous reset to zero and a hold while disabled;
// both outward level stages use it so they freeze and clear alike, and
// every request output comes straight from its flops
module pir_level_reg #(
    parameter int W = 1
) (
    // clock, reset, enable
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic clk_en,
    // next value in, registered value out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    // zero after reset is the quiet level of every request output
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            q <= '0;
        end else if (clk_en) begin
            q <= d;
        end
    end

endmodule

// ==== tb/pir_cards.sv ====
/* model of the pci cards and onboard agents on the interrupt pins.
   assumes the bench changes want right after a clock edge. */
module pir_cards
    import pir_pkg::*;
(
    // wanted requests: [3:0] slot 1, [7:4] slot 2, 8 ethernet, 9 1394
    input wire logic [9:0] want,
    // active-low pins
    output pir_pins_t slot_pins [PIR_SLOTS],
    output logic enet_int_a_n,
    output logic fw_int_a_n
);
    always_comb begin
        slot_pins[0] = ~want[3:0];
        slot_pins[1] = ~want[7:4];
        enet_int_a_n = ~want[8];
        fw_int_a_n = ~want[9];
    end
endmodule

// ==== tb/pir_router_sva.sv ====
/* port checker for the router.
   assumes pins idle during reset; frozen cycles are left out. */
module pir_router_sva
    import pir_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic clk_en,
    // watched ports
    input wire pir_pins_t slot_pins [PIR_SLOTS],
    input wire logic enet_int_a_n,
    input wire logic fw_int_a_n,
    input wire pir_wb_req_t wb_req,
    input wire logic wb_ack_o,
    input wire logic [PIR_IRQS-1:0] irq_out,
    input wire logic [PIR_LINES-1:0] shared_req_lines
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // a request counts only while no answer stands
    sequence wb_take;
        clk_en && wb_req.cyc && wb_req.stb && !wb_ack_o;
    endsequence
    // the three-edge pin path is clear of reset and of frozen cycles
    sequence settled;
        $past(nrst, 3) && $past(nrst, 2) && $past(nrst, 1)
            && $past(clk_en, 3) && $past(clk_en, 2) && $past(clk_en, 1);
    endsequence
    no_src_a:
        assert property (shared_req_lines[2:0] == 3'h0) else $error("lines a-c raised");
    line_d_a:
        assert property (settled |-> shared_req_lines[3] == !$past(fw_int_a_n, 3))
        else $error("line d wrong");
    line_e_a:
        assert property (settled |-> shared_req_lines[4] == $past(~(enet_int_a_n
            & slot_pins[0].int_d_n & slot_pins[1].int_c_n), 3)) else $error("line e wrong");
    slot_fgh_a:
        assert property (settled |-> shared_req_lines[7:5] == $past(~{
            slot_pins[0].int_c_n & slot_pins[1].int_d_n,
            slot_pins[0].int_b_n & slot_pins[1].int_a_n,
            slot_pins[0].int_a_n & slot_pins[1].int_b_n}, 3)) else $error("lines f-h wrong");
    adv_map_a:
        assert property ($past(clk_en) && irq_out[23:16] != 8'h00
            |-> irq_out[23:16] == $past(shared_req_lines))
        else $error("advanced map wrong");
    reserved_a:
        assert property (irq_out[2:0] == 3'h0 && !irq_out[8] && !irq_out[13])
        else $error("reserved irq driven");
    legacy_cause_a:
        assert property (irq_out[15:0] != 16'h0000 |-> $past(shared_req_lines) != 8'h00)
        else $error("irq without line");
    ack_time_a:
        assert property (wb_take |=> wb_ack_o) else $error("ack late");
    ack_pulse_a:
        assert property (wb_ack_o && clk_en |=> !wb_ack_o) else $error("ack too long");
endmodule

bind pir_router pir_router_sva chk (.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
    .slot_pins(slot_pins), .enet_int_a_n(enet_int_a_n), .fw_int_a_n(fw_int_a_n),
    .wb_req(wb_req), .wb_ack_o(wb_ack_o), .irq_out(irq_out),
    .shared_req_lines(shared_req_lines));

// ==== tb/pir_router_tb_top.sv ====
/* bench for the router: bus task and one task per scenario.
   assumes the card model drives all pins and clk_en stays high except in t_freeze. */
module pir_router_tb_top
    import pir_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic clk_en = 1'b1;
    logic [9:0] want = 10'h000;
    pir_wb_req_t wb_req = '0;
    pir_pins_t slot_pins [PIR_SLOTS];
    logic enet_int_a_n, fw_int_a_n, wb_ack_o;
    logic [31:0] wb_dat_o, rd;
    logic [23:0] irq_out;
    logic [7:0] shared_req_lines;
    logic [2:0] tgt [10] = '{3'h5, 3'h6, 3'h7, 3'h4, 3'h6, 3'h5, 3'h4, 3'h7, 3'h4, 3'h3};
    int n_errors = 0;
    int compares = 0;
    // 100 MHz clock
    always #5 core_clk = ~core_clk;
    pir_cards cards (.want(want), .slot_pins(slot_pins), .enet_int_a_n(enet_int_a_n),
        .fw_int_a_n(fw_int_a_n));
    pir_router dut (.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en), .slot_pins(slot_pins),
        .enet_int_a_n(enet_int_a_n), .fw_int_a_n(fw_int_a_n), .wb_req(wb_req),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_out(irq_out),
        .shared_req_lines(shared_req_lines));
    task automatic stop_test();
        $display("compares %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL %0t got %h want %h", $time, got, exp);
        end
    endtask
    // one classic cycle, held until ack is seen; entered at a rising edge
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int i = 0;
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: adr, dat: dat};
        do begin
            @(posedge core_clk);
            i++;
        end while (wb_ack_o !== 1'b1 && i < 20);
        rd = wb_dat_o;
        wb_req <= '0;
        if (wb_ack_o !== 1'b1) begin
            n_errors++;
            $display("FAIL %0t no ack", $time);
            stop_test();
        end
        @(posedge core_clk);
    endtask
    // pins change, then the path of four edges settles
    task automatic drive(input logic [9:0] w);
        want <= w;
        repeat (6) @(posedge core_clk);
    endtask
    task automatic t_reset();
        check(shared_req_lines, 32'h0);
        check(irq_out, 32'h0);
        wb(1'b0, PIR_OFF_CTRL, 32'h0);
        check(rd, 32'h0);
        wb(1'b0, PIR_OFF_STEER, 32'h0);
        check(rd, PIR_STEER_RST);
        wb(1'b0, 8'h10, 32'h0);
        check(rd, 32'h0);
        $display("reset test done");
    endtask
    task automatic t_adv();
        wb(1'b1, PIR_OFF_CTRL, 32'h1);
        for (int s = 0; s < 10; s++) begin
            drive(10'h001 << s);
            check(shared_req_lines, 32'h1 << tgt[s]);
            check(irq_out, 32'h1_0000 << tgt[s]);
        end
        drive(10'h148);
        wb(1'b0, PIR_OFF_LINES, 32'h0);
        check(rd, 32'h10);
        drive(10'h140);
        check(irq_out, 32'h10_0000);
        wb(1'b0, PIR_OFF_IRQS, 32'h0);
        check(rd, 32'h10_0000);
        drive(10'h000);
        check(irq_out, 32'h0);
        $display("advanced test done");
    endtask
    task automatic t_legacy();
        wb(1'b1, PIR_OFF_CTRL, 32'h0);
        for (int v = 0; v < 16; v++) begin
            wb(1'b1, PIR_OFF_STEER, 32'(v) << 20);
            drive(10'h001);
            check(irq_out, PIR_LEGACY_ALLOWED[v] ? 32'h1 << v : 32'h0);
            drive(10'h000);
        end
        wb(1'b1, PIR_OFF_STEER, 32'h00A0_A000);
        drive(10'h201);
        check(irq_out, 32'h400);
        drive(10'h200);
        check(irq_out, 32'h400);
        drive(10'h000);
        $display("legacy test done");
    endtask
    // clk_en low holds every flop; pins seen only once the enable returns
    task automatic t_freeze();
        clk_en <= 1'b0;
        want <= 10'h200;
        repeat (6) @(posedge core_clk);
        check(shared_req_lines, 32'h0);
        check(irq_out, 32'h0);
        clk_en <= 1'b1;
        repeat (6) @(posedge core_clk);
        check(shared_req_lines, 32'h08);
        check(irq_out, 32'h400);
        drive(10'h000);
        $display("freeze test done");
    endtask
    initial begin
        repeat (12) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        t_reset();
        t_adv();
        t_legacy();
        t_freeze();
        stop_test();
    end
endmodule
